// >>> verif/ocg_top_test.sv
/*
  Self-checking bench for the oscillator control block: register access,
  divider gating, trimming protection, clock switch interrupt, prescaler.
  Assumes ocg_pkg, ocg_cfg.svh and ocg_top are compiled before it.
*/
`include "ocg_cfg.svh"

module ocg_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ocg_pkg::*;

  logic                          mclk = 1'b0;
  logic                          rst_n = 1'b0;
  logic [4:0]                    avsAddress = 5'h00;
  logic                          avsRead = 1'b0;
  logic                          avsWrite = 1'b0;
  logic [31:0]                   avsWritedata = 32'h0000_0000;
  logic [3:0]                    avsByteenable = 4'hF;
  logic [31:0]                   avsReaddata;
  logic                          avsWaitrequest;
  ocg_osc_ctrl_s                 oscCtrl;
  logic [7:0]                    trimData;
  logic                          oscTick;
  logic                          extClockSelect;
  logic [`OCG_PRESC_STAGES-1:0]  divClk;
  logic                          irq;
  logic [31:0]                   expQ[$];
  logic [7:0]                    rnd = 8'h15;
  logic [12:0]                   cnt0;
  int                            miscompares = 0;
  int                            nCompared = 0;
  int                            k;

  always #20 mclk = ~mclk;

  ocg_top u_ocg_top (
    .mclk(mclk), .rst_n(rst_n), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .oscCtrl(oscCtrl),
    .trimData(trimData), .oscTick(oscTick), .extClockSelect(extClockSelect),
    .divClk(divClk), .irq(irq)
  );

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Read answers are matched against the oldest noted expectation
  always @(posedge mclk) begin
    if (avsRead === 1'b1 && avsWaitrequest === 1'b0) begin
      if (expQ.size() == 0) begin
        check(avsReaddata, 32'hFFFF_FFFF);
      end else begin
        check(avsReaddata, expQ.pop_front());
      end
    end
  end

  // ****************************************
  // Bus master and helpers
  // ****************************************
  task automatic busop(input logic wr, input logic [4:0] a, input logic [7:0] d,
                       input logic [3:0] be, input logic [7:0] e);
    int n;
    if (!wr) expQ.push_back({24'h00_0000, e});
    avsAddress    <= a;
    avsWrite      <= wr;
    avsRead       <= !wr;
    avsWritedata  <= {24'h00_0000, d};
    avsByteenable <= be;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 20);
    if (avsWaitrequest !== 1'b0) begin
      miscompares++;
      $display("CHECK FAILED at %0t: bus answer timed out", $time);
      summarize();
    end
    avsWrite <= 1'b0;
    avsRead  <= 1'b0;
    // One idle edge so no strobe is driven twice in a time step
    @(posedge mclk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    busop(1'b1, a, d, 4'hF, 8'h00);
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    busop(1'b0, a, 8'h00, 4'hF, e);
  endtask

  task automatic ticks(input int exp);
    int t;
    t = 0;
    repeat (4) @(posedge mclk);
    repeat (8) begin
      @(posedge mclk);
      if (oscTick === 1'b1) t++;
    end
    check(t, exp);
  endtask

  task automatic doReset();
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
  endtask

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(`OCG_ADDR_OSC_CTRL, 8'h00);
    rd(`OCG_ADDR_TRIM_PROT, 8'h8F);
    rd(`OCG_ADDR_TRIM_DATA, 8'h00);
    check(extClockSelect, 1'b0);
    wr(`OCG_ADDR_OSC_CTRL, 8'hFF);
    rd(`OCG_ADDR_OSC_CTRL, 8'hE3);
    check(oscCtrl, 5'h1F);
    busop(1'b1, `OCG_ADDR_OSC_CTRL, 8'h00, 4'hE, 8'h00);
    rd(`OCG_ADDR_OSC_CTRL, 8'hE3);
    wr(`OCG_ADDR_OSC_CTRL, 8'h80);
    ticks(0);
    for (k = 0; k < 4; k++) begin
      wr(`OCG_ADDR_OSC_CTRL, k[7:0]);
      ticks(k < 2 ? 8 : (k == 2 ? 4 : 2));
    end
    // Interrupt raised through the enable, then masked
    wr(`OCG_ADDR_IRQ_MASK, 8'h01);
    wr(`OCG_ADDR_CLK_SWITCH, 8'h10);
    rd(`OCG_ADDR_CLK_SWITCH, 8'h11);
    check(extClockSelect, 1'b1);
    wr(`OCG_ADDR_OSC_CTRL, 8'h41);
    rd(`OCG_ADDR_OSC_CTRL, 8'h43);
    check(irq, 1'b0);
    wr(`OCG_ADDR_CLK_SWITCH, 8'h00);
    repeat (4) @(posedge mclk);
    check(irq, 1'b1);
    rd(`OCG_ADDR_IRQ_STAT, 8'h01);
    repeat (2) @(posedge mclk);
    check(irq, 1'b0);
    rd(`OCG_ADDR_IRQ_STAT, 8'h00);
    wr(`OCG_ADDR_IRQ_MASK, 8'h00);
    wr(`OCG_ADDR_CLK_SWITCH, 8'h10);
    wr(`OCG_ADDR_CLK_SWITCH, 8'h00);
    repeat (4) @(posedge mclk);
    check(irq, 1'b0);
    rd(`OCG_ADDR_IRQ_STAT, 8'h01);
    wr(`OCG_ADDR_OSC_CTRL, 8'h02);
    rd(`OCG_ADDR_OSC_CTRL, 8'h02);
    // Protection chain
    wr(`OCG_ADDR_TRIM_PROT, 8'hF0);
    rd(`OCG_ADDR_TRIM_PROT, 8'h8F);
    wr(`OCG_ADDR_TRIM_PROT, 8'h10);
    rd(`OCG_ADDR_TRIM_PROT, 8'h8F);
    wr(`OCG_ADDR_TRIM_DATA, 8'hFF);
    rd(`OCG_ADDR_TRIM_DATA, 8'h00);
    wr(`OCG_ADDR_TRIM_PROT, 8'h40);
    rd(`OCG_ADDR_TRIM_PROT, 8'hCF);
    wr(`OCG_ADDR_TRIM_PROT, 8'h50);
    rd(`OCG_ADDR_TRIM_PROT, 8'hDF);
    for (k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      wr(`OCG_ADDR_TRIM_DATA, rnd);
      rd(`OCG_ADDR_TRIM_DATA, rnd & 8'hFC);
    end
    wr(`OCG_ADDR_TRIM_DATA, 8'hFF);
    check(trimData, 8'hFC);
    wr(`OCG_ADDR_TRIM_PROT, 8'h40);
    rd(`OCG_ADDR_TRIM_PROT, 8'hCF);
    wr(`OCG_ADDR_TRIM_DATA, 8'h00);
    rd(`OCG_ADDR_TRIM_DATA, 8'hFC);
    wr(`OCG_ADDR_TRIM_PROT, 8'h50);
    wr(`OCG_ADDR_TRIM_PROT, 8'h00);
    rd(`OCG_ADDR_TRIM_PROT, 8'h8F);
    wr(`OCG_ADDR_TRIM_PROT, 8'h40);
    wr(`OCG_ADDR_TRIM_PROT, 8'h70);
    rd(`OCG_ADDR_TRIM_PROT, 8'hFF);
    wr(`OCG_ADDR_TRIM_DATA, 8'h00);
    rd(`OCG_ADDR_TRIM_DATA, 8'hFC);
    wr(`OCG_ADDR_TRIM_PROT, 8'h50);
    rd(`OCG_ADDR_TRIM_PROT, 8'hFF);
    // bitwise update writes back the inhibit bit as read
    wr(`OCG_ADDR_TRIM_PROT, 8'hCF);
    rd(`OCG_ADDR_TRIM_PROT, 8'hFF);
    wr(5'h1C, 8'hFF);
    rd(5'h18, 8'h00);
    doReset();
    rd(`OCG_ADDR_TRIM_PROT, 8'h8F);
    rd(`OCG_ADDR_TRIM_DATA, 8'h00);
    // Prescaler counts one per clock up to the divide by 8192 tap
    cnt0 = divClk;
    repeat (100) @(posedge mclk);
    check(divClk - cnt0, 13'd100);
    k = 0;
    while (divClk[12] !== 1'b1 && k < 8200) begin
      @(posedge mclk);
      k++;
    end
    check(divClk[12], 1'b1);
    summarize();
  end
endmodule // ocg_top_test

// >>> verilog/ocg_cfg.svh
/*
  Offsets, field positions, reset values and counts of the on-chip
  oscillator control block. Assumes byte addresses on a 32-bit bus.
*/
`ifndef OCG_CFG_SVH
`define OCG_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OCG_ADDR_OSC_CTRL   5'h00
`define OCG_ADDR_TRIM_PROT  5'h04
`define OCG_ADDR_TRIM_DATA  5'h08
`define OCG_ADDR_CLK_SWITCH 5'h0C
`define OCG_ADDR_IRQ_STAT   5'h10
`define OCG_ADDR_IRQ_MASK   5'h14

// ****************************************
// Field positions
// ****************************************
`define OCG_OSC_STANDBY_BIT 7
`define OCG_OSC_FREQ_BIT    6
`define OCG_OSC_SUPPLY_BIT  5
`define OCG_OSC_DIV_HI_BIT  1
`define OCG_OSC_DIV_LO_BIT  0
`define OCG_PROT_WI_BIT     7
`define OCG_PROT_PWE_BIT    6
`define OCG_PROT_LOCK_BIT   5
`define OCG_PROT_TWE_BIT    4
`define OCG_CSW_REQ_BIT     4
`define OCG_CSW_STAT_BIT    0
`define OCG_IRQ_SWITCH_BIT  0

// ****************************************
// Reset values and counts
// ****************************************
`define OCG_OSC_CTRL_RST    5'h00
`define OCG_TRIM_DATA_RST   8'h00
`define OCG_PROT_RSVD_READ  4'hF
`define OCG_PRESC_STAGES    13
`define OCG_OSC_DIV_MAX     2'h3

`endif

// >>> verilog/ocg_osc_div.sv
/*
  Oscillator output divider: passes, halves or quarters the oscillator
  tick. Assumes the oscillator is modelled on mclk.
*/
`include "ocg_cfg.svh"

module ocg_osc_div (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       standby,
  input  wire logic [1:0] divider,
  // Divided oscillator tick
  output logic            oscTick
);

  logic [1:0] count;
  logic [1:0] lastDivider;

  // Restart on a ratio change so the new ratio applies at once
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      count       <= 2'h0;
      lastDivider <= 2'h0;
    end else begin
      lastDivider <= divider;
      if (divider != lastDivider || standby) begin
        count <= 2'h0;
      end else begin
        count <= count + 2'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      oscTick <= 1'b0;
    end else if (standby) begin
      oscTick <= 1'b0;
    end else begin
      unique case (divider)
        2'h2:    oscTick <= ~count[0];
        2'h3:    oscTick <= (count == `OCG_OSC_DIV_MAX);
        default: oscTick <= 1'b1;
      endcase
    end
  end

endmodule // ocg_osc_div

// >>> verilog/ocg_pkg.sv
/*
  Types of the on-chip oscillator control block.
  Assumes nothing beyond the constants header.
*/
package ocg_pkg;

  // Oscillator control fields
  typedef struct packed {
    logic       standby;
    logic       freqSelect;
    logic       supplySelect;
    logic [1:0] divider;
  } ocg_osc_ctrl_s;

  // Bus answer sequencing
  typedef enum logic {
    BUS_IDLE,
    BUS_ANSWER
  } ocg_bus_e;

  // Register decode
  typedef enum logic [2:0] {
    SEL_OSC_CTRL,
    SEL_TRIM_PROT,
    SEL_TRIM_DATA,
    SEL_CLK_SWITCH,
    SEL_IRQ_STAT,
    SEL_IRQ_MASK,
    SEL_NONE
  } ocg_sel_e;

endpackage

// >>> verilog/ocg_prescaler.sv
/*
  Free-running system clock prescaler giving mclk/2 up to mclk/8192.
  Assumes a single clock and synchronous active-low reset.
*/
`include "ocg_cfg.svh"

module ocg_prescaler #(
  parameter int STAGES = `OCG_PRESC_STAGES
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // Divided clocks, bit k is mclk/2^(k+1)
  output logic [STAGES-1:0]      divClk
);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      divClk <= '0;
    end else begin
      divClk <= divClk + 1'b1;
    end
  end

endmodule // ocg_prescaler

// >>> verilog/ocg_top.sv
/*
  On-chip oscillator control, trimming write protection, clock source
  switch, interrupt and prescaler, with an Avalon-MM slave.
  Assumes one clock mclk, synchronous active-low reset, byte addresses.
*/
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
// Functional notes
// - Prescaler gives mclk/2 up to mclk/8192 to peripherals.
// - Switch from external to internal clock raises an interrupt.
// - Reset runs from internal oscillator; external only on request.
// - Standby bit 7 puts oscillator in standby; resets to 0.
// - Bit 6 selects 8 MHz (0) or 10 MHz (1); resets 0.
// - Bit 5 selects bandgap (0) or core supply (1) reference.
// - Control bits 4 to 2 read as 0.
// - Divider 0X undivided, 10 by two, 11 by four, immediate.
// - Divider writes accepted only while clock status is 0.
// - Protect write accepted only with bit 7 zero; reads 1.
// - Protect enable bit 6 follows accepted writes; reset clears.
// - Bits 5 and 4 change only while protect enable is 1.
// - Lockdown bit 5 sets on enabled write, cleared only by reset.
// - Lockdown blocks every trimming data write.
// - Trim enable bit 4 follows enabled writes; reset clears.
// - Trimming data writable only with lockdown 0, trim enable 1.
// - Protect bits 3 to 0 read as 1.
`include "ocg_cfg.svh"

module ocg_top (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // Avalon-MM slave
  input  wire logic [4:0]            avsAddress,
  input  wire logic                  avsRead,
  input  wire logic                  avsWrite,
  input  wire logic [31:0]           avsWritedata,
  input  wire logic [3:0]            avsByteenable,
  output logic [31:0]                avsReaddata,
  output logic                       avsWaitrequest,
  // Oscillator controls
  output ocg_pkg::ocg_osc_ctrl_s     oscCtrl,
  output logic [7:0]                 trimData,
  output logic                       oscTick,
  // Clock source
  output logic                       extClockSelect,
  // Prescaler
  output logic [`OCG_PRESC_STAGES-1:0] divClk,
  // Interrupt
  output logic                       irq
);
  import ocg_pkg::*;

  // ****************************************
  // Decode
  // ****************************************
  function automatic ocg_sel_e regSel(input logic [4:0] addr);
    unique case (addr)
      `OCG_ADDR_OSC_CTRL:   regSel = SEL_OSC_CTRL;
      `OCG_ADDR_TRIM_PROT:  regSel = SEL_TRIM_PROT;
      `OCG_ADDR_TRIM_DATA:  regSel = SEL_TRIM_DATA;
      `OCG_ADDR_CLK_SWITCH: regSel = SEL_CLK_SWITCH;
      `OCG_ADDR_IRQ_STAT:   regSel = SEL_IRQ_STAT;
      `OCG_ADDR_IRQ_MASK:   regSel = SEL_IRQ_MASK;
      default:              regSel = SEL_NONE;
    endcase
  endfunction

  ocg_bus_e   busState;
  logic       protEnable;
  logic       trimLock;
  logic       trimEnable;
  logic       clockSource;
  logic [0:0] irqStatus;
  logic [0:0] irqMask;
  logic [0:0] switchEvent;
  logic       commit;
  logic       doWrite;
  logic       doRead;
  logic [7:0] wByte;
  ocg_sel_e   sel;
  logic [31:0] next_readdata;

  assign sel     = regSel(avsAddress);
  assign commit  = (busState == BUS_ANSWER);
  assign doWrite = commit && avsWrite && avsByteenable[0];
  assign doRead  = commit && avsRead;
  assign wByte   = avsWritedata[7:0];

  // ****************************************
  // Bus answer
  // ****************************************
  // Fixed two-cycle answer keeps read data stable for the master
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      busState       <= BUS_IDLE;
      avsWaitrequest <= 1'b1;
    end else begin
      unique case (busState)
        BUS_IDLE: begin
          if (avsRead || avsWrite) begin
            busState       <= BUS_ANSWER;
            avsWaitrequest <= 1'b0;
          end
        end
        BUS_ANSWER: begin
          busState       <= BUS_IDLE;
          avsWaitrequest <= 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    next_readdata = 32'h0000_0000;
    unique case (sel)
      SEL_OSC_CTRL: begin
        next_readdata[`OCG_OSC_STANDBY_BIT] = oscCtrl.standby;
        next_readdata[`OCG_OSC_FREQ_BIT]    = oscCtrl.freqSelect;
        next_readdata[`OCG_OSC_SUPPLY_BIT]  = oscCtrl.supplySelect;
        next_readdata[`OCG_OSC_DIV_HI_BIT]  = oscCtrl.divider[1];
        next_readdata[`OCG_OSC_DIV_LO_BIT]  = oscCtrl.divider[0];
      end
      SEL_TRIM_PROT: begin
        // inhibit reads 1, so bitwise update fails
        next_readdata[`OCG_PROT_WI_BIT]   = 1'b1;
        next_readdata[`OCG_PROT_PWE_BIT]  = protEnable;
        next_readdata[`OCG_PROT_LOCK_BIT] = trimLock;
        next_readdata[`OCG_PROT_TWE_BIT]  = trimEnable;
        next_readdata[3:0] = `OCG_PROT_RSVD_READ;
      end
      SEL_TRIM_DATA: begin
        next_readdata[7:0] = {trimData[7:2], 2'h0};
      end
      SEL_CLK_SWITCH: begin
        next_readdata[`OCG_CSW_REQ_BIT]  = extClockSelect;
        next_readdata[`OCG_CSW_STAT_BIT] = clockSource;
      end
      SEL_IRQ_STAT: next_readdata[0:0] = irqStatus;
      SEL_IRQ_MASK: next_readdata[0:0] = irqMask;
      SEL_NONE:     next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      avsReaddata <= 32'h0000_0000;
    end else if (busState == BUS_IDLE && avsRead) begin
      avsReaddata <= next_readdata;
    end
  end

  // ****************************************
  // Oscillator control
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      oscCtrl <= `OCG_OSC_CTRL_RST;
    end else if (doWrite && sel == SEL_OSC_CTRL) begin
      oscCtrl.standby      <= wByte[`OCG_OSC_STANDBY_BIT];
      oscCtrl.freqSelect   <= wByte[`OCG_OSC_FREQ_BIT];
      oscCtrl.supplySelect <= wByte[`OCG_OSC_SUPPLY_BIT];
      if (!clockSource) begin
        oscCtrl.divider <= {wByte[`OCG_OSC_DIV_HI_BIT], wByte[`OCG_OSC_DIV_LO_BIT]};
      end
    end
  end

  ocg_osc_div u_osc_div (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .standby (oscCtrl.standby),
    .divider (oscCtrl.divider),
    .oscTick (oscTick)
  );

  // ****************************************
  // Trimming protection
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      protEnable <= 1'b0;
      trimLock   <= 1'b0;
      trimEnable <= 1'b0;
    end else if (doWrite && sel == SEL_TRIM_PROT && !wByte[`OCG_PROT_WI_BIT]) begin
      protEnable <= wByte[`OCG_PROT_PWE_BIT];
      if (protEnable) begin
        trimLock   <= trimLock | wByte[`OCG_PROT_LOCK_BIT];
        trimEnable <= wByte[`OCG_PROT_TWE_BIT];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      trimData <= `OCG_TRIM_DATA_RST;
    end else if (doWrite && sel == SEL_TRIM_DATA && trimEnable && !trimLock) begin
      trimData <= {wByte[7:2], 2'h0};
    end
  end

  // ****************************************
  // Clock source switch
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      extClockSelect <= 1'b0;
      clockSource    <= 1'b0;
    end else begin
      if (doWrite && sel == SEL_CLK_SWITCH) begin
        extClockSelect <= wByte[`OCG_CSW_REQ_BIT];
      end
      clockSource <= extClockSelect;
    end
  end

  // ****************************************
  // Interrupt
  // ****************************************
  assign switchEvent[`OCG_IRQ_SWITCH_BIT] = clockSource && !extClockSelect;

  // sticky switch event, set beats read clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irqStatus <= '0;
    end else if (doRead && sel == SEL_IRQ_STAT) begin
      irqStatus <= (irqStatus & ~avsReaddata[0:0]) | switchEvent;
    end else begin
      irqStatus <= irqStatus | switchEvent;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irqMask <= '0;
    end else if (doWrite && sel == SEL_IRQ_MASK) begin
      irqMask <= wByte[0:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus & irqMask);
    end
  end

  // ****************************************
  // Prescaler
  // ****************************************
  // peripheral divided clocks
  ocg_prescaler #(
    .STAGES (`OCG_PRESC_STAGES)
  ) u_prescaler (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .divClk (divClk)
  );

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  logic protWrite;
  assign protWrite = doWrite && sel == SEL_TRIM_PROT;

  lockdown_sticky_a: assert property (trimLock |=> trimLock)
    else $error("lockdown cleared without reset");

  inhibit_gate_a: assert property (
    protWrite && wByte[`OCG_PROT_WI_BIT]
      |=> $stable(protEnable) && $stable(trimLock) && $stable(trimEnable))
    else $error("protect write taken with inhibit set");

  prot_enable_a: assert property (
    protWrite && !wByte[`OCG_PROT_WI_BIT]
      |=> protEnable == $past(wByte[`OCG_PROT_PWE_BIT]))
    else $error("protect enable did not follow write");

  field_hold_a: assert property (
    protWrite && !protEnable |=> $stable(trimEnable) && $stable(trimLock))
    else $error("protected fields changed while disabled");

  lock_set_a: assert property (
    protWrite && !wByte[`OCG_PROT_WI_BIT] && protEnable && wByte[`OCG_PROT_LOCK_BIT]
      |=> trimLock)
    else $error("lockdown not set by enabled write");

  trim_enable_a: assert property (
    protWrite && !wByte[`OCG_PROT_WI_BIT] && protEnable
      |=> trimEnable == $past(wByte[`OCG_PROT_TWE_BIT]))
    else $error("trim enable did not follow enabled write");

  standby_tick_a: assert property (
    oscCtrl.standby |=> !oscTick)
    else $error("oscillator ticks while in standby");

  trim_gate_a: assert property (
    !$stable(trimData) |-> $past(trimEnable && !trimLock && doWrite && sel == SEL_TRIM_DATA))
    else $error("trimming data changed while protected");

  div_gate_a: assert property (
    doWrite && sel == SEL_OSC_CTRL && clockSource |=> $stable(oscCtrl.divider))
    else $error("divider written on external clock");

  osc_reserved_a: assert property (
    doRead && sel == SEL_OSC_CTRL |-> avsReaddata[4:2] == 3'h0)
    else $error("control reserved bits not zero");

  prot_readback_a: assert property (
    doRead && sel == SEL_TRIM_PROT
      |-> avsReaddata[3:0] == 4'hF && avsReaddata[`OCG_PROT_WI_BIT])
    else $error("protect readback wrong");

  switch_irq_a: assert property (
    clockSource && !extClockSelect && irqMask[0] |=> irqStatus[0] ##1 irq)
    else $error("switch event did not raise interrupt");

  answer_time_a: assert property (
    busState == BUS_IDLE && (avsRead || avsWrite) |=> !avsWaitrequest ##1 avsWaitrequest)
    else $error("bus answer not two cycles");

  lock_set_c: cover property (protWrite && protEnable ##1 trimLock);
  trim_write_c: cover property (!$stable(trimData));
  irq_raise_c: cover property ($rose(irq));
  div_quarter_c: cover property (oscCtrl.divider == 2'h3 && oscTick);

endmodule // ocg_top
